// *** src/scs_regs.vh ***
// register offsets, fields and timing counts of the clock switch sequencer
`ifndef SCS_REGS_VH
`define SCS_REGS_VH

`define SCS_OFF_CTRL        12'h000
`define SCS_OFF_CFG         12'h008
`define SCS_OFF_IRQ_EN      12'h018
`define SCS_OFF_IRQ_STAT    12'h01C
`define SCS_OFF_CHG_CMD     12'h020
`define SCS_OFF_RADIO       12'h060
`define SCS_OFF_IRQ_CLR     12'h024

// control register fields
`define SCS_CTRL_PLL_RDY    13
`define SCS_CTRL_PLL_ON     12
`define SCS_CTRL_XTAL_EN    16
`define SCS_CTRL_XTAL_RDY   17

// configuration register fields
`define SCS_CFG_SEL_BIT     1
`define SCS_CFG_STOP_BIT    2
`define SCS_CFG_DIV_LSB     5
`define SCS_CFG_DIV_MSB     7

// change command register fields
`define SCS_CMD_REQ_BIT     0
`define SCS_CMD_DIV_LSB     1
`define SCS_CMD_DIV_MSB     3
`define SCS_CMD_ST_LSB      4
`define SCS_CMD_ST_MSB      5
`define SCS_CMD_IE_BIT      6
`define SCS_CMD_DONE_BIT    7

// status / enable bit positions
`define SCS_EV_XTAL_RDY     3
`define SCS_EV_PLL_RDY      4
`define SCS_EV_UNLOCK       5
`define SCS_EV_DONE         6

// divider codes: 0 = 64 MHz, 1 = 32 MHz, 2 = 16 MHz, >2 slower
`define SCS_DIV_64M         3'h0
`define SCS_DIV_16M         3'h2
`define SCS_DIV_RESET       3'h1

// clock path codes
`define SCS_PATH_RC         2'h0
`define SCS_PATH_PLL        2'h1
`define SCS_PATH_XTAL       2'h2

// switch-over time in cycles
`define SCS_SWITCH_CYCLES   3'h4

`endif

// *** src/scs_clock_switch.v ***
// fast clock tree switch sequencer with apb registers
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "scs_regs.vh"

// Functional notes
// [RL1] software enables crystal, waits ready, requests pll, waits pll ready
// [RL2] once pll ready, fast clock tree runs from the pll output
// [RL3] pll unlock sets a status flag with an enableable interrupt
// [RL4] static mode runs the fast tree directly from the crystal
// [RL5] software sets divider below 64 MHz and waits crystal ready first
// [RL6] crystal select moves the tree to crystal in about four cycles
// [RL7] in crystal mode the stop bit powers down the rc oscillator and pll
// [RL8] crystal loss or 64 MHz divider restarts rc/pll and switches back
// [RL9] crystal enable survives deep-stop; tree resumes on the internal source
// [RL10] software returns to internal source before deep-stop, reprograms after
// [RL11] software avoids source switches once radio wakeup has begun
// [RL12] with radio clock on, frequency changes only via change request
// [RL13] software keeps the target frequency at or above the radio clock
// [RL14] software writes requested divider then sets the request bit
// [RL15] on completion set done flag, interrupt if enabled, new frequency
// [RL16] completion updates the system divider field to the new value
// [RL17] requests below 16 MHz run and report 16 MHz instead
// [RL18] a 16 MHz request with radio at 32 MHz is still applied
module scs_clock_switch (
    // clock and reset
    input  wire        clk_in,
    input  wire        rst_n_in,
    // apb slave
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [11:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out,
    // analog status
    input  wire        crystal_ready_in,
    input  wire        pll_ready_in,
    input  wire        pll_lock_in,
    input  wire        deep_stop_wake_in,
    // analog controls and clock tree
    output reg         crystal_enable_out,
    output reg         internal_osc_pll_on_out,
    output reg         pll_enable_out,
    output reg  [1:0]  clock_path_out,
    output reg  [2:0]  sys_clock_divider_out,
    output reg         radio_clock_enable_out,
    output reg  [1:0]  radio_clock_divider_out,
    // interrupt
    output reg         irq_out
);

//------------------------------------------------------------
// states of the path switch
//------------------------------------------------------------
localparam [3:0] ST_RC   = 4'h1;
localparam [3:0] ST_PLL  = 4'h2;
localparam [3:0] ST_SWX  = 4'h4;
localparam [3:0] ST_XTAL = 4'h8;

//------------------------------------------------------------
// registers
//------------------------------------------------------------
reg        xtal_en_reg;
reg        pll_on_reg;
reg        xtal_sel_reg;
reg        osc_stop_reg;
reg [2:0]  div_reg;
reg [2:0]  req_div_reg;
reg        req_reg;
reg [1:0]  req_stage_reg;
reg        done_ie_reg;
reg [6:0]  ev_en_reg;
reg [6:0]  ev_stat_reg;
reg        radio_en_reg;
reg [1:0]  radio_div_reg;
reg [3:0]  state_reg;
reg [3:0]  state_next;
reg [2:0]  sw_cnt_reg;
reg        xtal_rdy_d_reg;
reg        pll_rdy_d_reg;
reg        lock_d_reg;

//------------------------------------------------------------
// apb decode
//------------------------------------------------------------
wire       wr    = psel_in & penable_in & pwrite_in & pready_out;
wire       known = (paddr_in == `SCS_OFF_CTRL)   ||
                   (paddr_in == `SCS_OFF_CFG)    ||
                   (paddr_in == `SCS_OFF_IRQ_EN) ||
                   (paddr_in == `SCS_OFF_IRQ_STAT) ||
                   (paddr_in == `SCS_OFF_IRQ_CLR) ||
                   (paddr_in == `SCS_OFF_CHG_CMD) ||
                   (paddr_in == `SCS_OFF_RADIO);
wire       wr_ctrl  = wr & (paddr_in == `SCS_OFF_CTRL);
wire       wr_cfg   = wr & (paddr_in == `SCS_OFF_CFG);
wire       wr_ien   = wr & (paddr_in == `SCS_OFF_IRQ_EN);
wire       wr_clr   = wr & (paddr_in == `SCS_OFF_IRQ_CLR);
wire       wr_cmd   = wr & (paddr_in == `SCS_OFF_CHG_CMD);
wire       wr_radio = wr & (paddr_in == `SCS_OFF_RADIO);

// clamp slow requests to 16 MHz
wire [2:0] req_eff = (req_div_reg > `SCS_DIV_16M) ? `SCS_DIV_16M
                                                   : req_div_reg; // RL17 RL18

// events (ready rising edges, pll lock falling edge, request done)
wire       ev_xtal   = crystal_ready_in & ~xtal_rdy_d_reg;
wire       ev_pll    = pll_ready_in & ~pll_rdy_d_reg;
wire       ev_unlock = ~pll_lock_in & lock_d_reg & pll_on_reg; // RL3
wire       ev_done   = req_reg & (req_stage_reg == 2'h3);

// fallback: crystal lost or 64 MHz wanted
wire       fallback  = ~crystal_ready_in |
                       (div_reg == `SCS_DIV_64M); // RL8

wire [6:0] ev_set;
assign ev_set = {ev_done, ev_unlock, ev_pll, ev_xtal, 3'h0};

//------------------------------------------------------------
// path state machine
//------------------------------------------------------------
always @* begin
    state_next = state_reg;
    case (state_reg)
        ST_RC: begin
            if (xtal_sel_reg && !fallback)
                state_next = ST_SWX; // RL4 RL6
            else if (pll_on_reg && pll_ready_in)
                state_next = ST_PLL; // RL2
        end
        ST_PLL: begin
            if (xtal_sel_reg && !fallback)
                state_next = ST_SWX;
            else if (!pll_on_reg || !pll_ready_in)
                state_next = ST_RC;
        end
        ST_SWX: begin
            if (!xtal_sel_reg || fallback)
                state_next = ST_RC; // RL8
            else if (sw_cnt_reg == `SCS_SWITCH_CYCLES - 3'h1)
                state_next = ST_XTAL; // RL6
        end
        ST_XTAL: begin
            if (!xtal_sel_reg || fallback)
                state_next = ST_RC; // RL8
        end
        default: state_next = ST_RC;
    endcase
end

//------------------------------------------------------------
// sequential logic
//------------------------------------------------------------
always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        xtal_en_reg    <= 1'b0;
        pll_on_reg     <= 1'b0;
        xtal_sel_reg   <= 1'b0;
        osc_stop_reg   <= 1'b0;
        div_reg        <= `SCS_DIV_RESET;
        req_div_reg    <= 3'h0;
        req_reg        <= 1'b0;
        req_stage_reg  <= 2'h0;
        done_ie_reg    <= 1'b0;
        ev_en_reg      <= 7'h00;
        ev_stat_reg    <= 7'h00;
        radio_en_reg   <= 1'b0;
        radio_div_reg  <= 2'h1;
        state_reg      <= ST_RC;
        sw_cnt_reg     <= 3'h0;
        xtal_rdy_d_reg <= 1'b0;
        pll_rdy_d_reg  <= 1'b0;
        lock_d_reg     <= 1'b0;
    end else begin
        xtal_rdy_d_reg <= crystal_ready_in;
        pll_rdy_d_reg  <= pll_ready_in;
        lock_d_reg     <= pll_lock_in;
        state_reg      <= state_next;
        sw_cnt_reg     <= (state_reg == ST_SWX) ? sw_cnt_reg + 3'h1 : 3'h0;
        if (wr_ctrl) begin
            xtal_en_reg <= pwdata_in[`SCS_CTRL_XTAL_EN];
            pll_on_reg  <= pwdata_in[`SCS_CTRL_PLL_ON];
        end
        // deep-stop wake: crystal enable kept, select dropped
        if (deep_stop_wake_in) begin
            xtal_sel_reg <= 1'b0; // RL9
            osc_stop_reg <= 1'b0;
        end else if (wr_cfg) begin
            xtal_sel_reg <= pwdata_in[`SCS_CFG_SEL_BIT];
            osc_stop_reg <= pwdata_in[`SCS_CFG_STOP_BIT];
        end else if (fallback && xtal_sel_reg) begin
            xtal_sel_reg <= 1'b0; // RL8
            osc_stop_reg <= 1'b0;
        end
        // direct divider writes ignored while radio is clocked
        if (ev_done)
            div_reg <= req_eff; // RL16 RL17
        else if (wr_cfg && !radio_en_reg)
            div_reg <= pwdata_in[`SCS_CFG_DIV_MSB:`SCS_CFG_DIV_LSB]; // RL12
        if (wr_cmd) begin
            req_div_reg <= pwdata_in[`SCS_CMD_DIV_MSB:`SCS_CMD_DIV_LSB];
            done_ie_reg <= pwdata_in[`SCS_CMD_IE_BIT];
        end
        // short settle so radio bus accesses drain before the switch
        if (ev_done) begin
            req_reg       <= 1'b0;
            req_stage_reg <= 2'h0;
        end else if (req_reg) begin
            req_stage_reg <= req_stage_reg + 2'h1; // RL12
        end else if (wr_cmd && pwdata_in[`SCS_CMD_REQ_BIT]) begin
            req_reg <= 1'b1;
        end
        if (wr_ien)
            ev_en_reg <= pwdata_in[6:0];
        if (wr_radio) begin
            radio_en_reg  <= pwdata_in[0];
            radio_div_reg <= pwdata_in[2:1];
        end
        // set wins over clear
        ev_stat_reg <= (ev_stat_reg & ~(wr_clr ? pwdata_in[6:0] : 7'h00))
                       | ev_set; // RL15
    end
end

//------------------------------------------------------------
// outputs and read data
//------------------------------------------------------------
always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        prdata_out              <= 32'h0000_0000;
        pready_out              <= 1'b0;
        pslverr_out             <= 1'b0;
        crystal_enable_out      <= 1'b0;
        internal_osc_pll_on_out <= 1'b1;
        pll_enable_out          <= 1'b0;
        clock_path_out          <= `SCS_PATH_RC;
        sys_clock_divider_out   <= `SCS_DIV_RESET;
        radio_clock_enable_out  <= 1'b0;
        radio_clock_divider_out <= 2'h1;
        irq_out                 <= 1'b0;
    end else begin
        // one wait state: answer in the second access cycle
        pready_out  <= psel_in & penable_in & ~pready_out;
        pslverr_out <= psel_in & penable_in & ~pready_out & ~known;
        prdata_out  <= 32'h0000_0000;
        if (psel_in && penable_in && !pready_out && !pwrite_in) begin
            case (paddr_in)
                `SCS_OFF_CTRL: begin
                    prdata_out[`SCS_CTRL_XTAL_RDY] <= crystal_ready_in;
                    prdata_out[`SCS_CTRL_XTAL_EN]  <= xtal_en_reg;
                    prdata_out[`SCS_CTRL_PLL_RDY]  <= pll_ready_in;
                    prdata_out[`SCS_CTRL_PLL_ON]   <= pll_on_reg;
                end
                `SCS_OFF_CFG: begin
                    prdata_out[`SCS_CFG_DIV_MSB:`SCS_CFG_DIV_LSB] <= div_reg;
                    prdata_out[`SCS_CFG_STOP_BIT] <= osc_stop_reg;
                    prdata_out[`SCS_CFG_SEL_BIT]  <= xtal_sel_reg;
                end
                `SCS_OFF_IRQ_EN:   prdata_out[6:0] <= ev_en_reg;
                `SCS_OFF_IRQ_STAT: prdata_out[6:0] <= ev_stat_reg;
                `SCS_OFF_CHG_CMD: begin
                    prdata_out[`SCS_CMD_DONE_BIT] <= ev_stat_reg[`SCS_EV_DONE];
                    prdata_out[`SCS_CMD_IE_BIT]   <= done_ie_reg;
                    prdata_out[`SCS_CMD_ST_MSB:`SCS_CMD_ST_LSB] <=
                        req_stage_reg;
                    prdata_out[`SCS_CMD_DIV_MSB:`SCS_CMD_DIV_LSB] <=
                        req_div_reg;
                    prdata_out[`SCS_CMD_REQ_BIT]  <= req_reg;
                end
                `SCS_OFF_RADIO:
                    prdata_out[2:0] <= {radio_div_reg, radio_en_reg};
                default: prdata_out <= 32'h0000_0000;
            endcase
        end
        crystal_enable_out      <= xtal_en_reg; // RL9
        // stop only honoured while tree is on the crystal
        internal_osc_pll_on_out <= ~(osc_stop_reg &
                                     (state_reg == ST_XTAL) &
                                     ~fallback); // RL7 RL8
        pll_enable_out          <= pll_on_reg & ~(osc_stop_reg &
                                     (state_reg == ST_XTAL));
        case (state_reg)
            ST_PLL:  clock_path_out <= `SCS_PATH_PLL; // RL2
            ST_XTAL: clock_path_out <= `SCS_PATH_XTAL; // RL4
            default: clock_path_out <= `SCS_PATH_RC;
        endcase
        sys_clock_divider_out   <= div_reg;
        radio_clock_enable_out  <= radio_en_reg;
        radio_clock_divider_out <= radio_div_reg;
        irq_out <= |(ev_stat_reg & ev_en_reg) |
                   (ev_stat_reg[`SCS_EV_DONE] & done_ie_reg); // RL3 RL15
    end
end

endmodule // scs_clock_switch

// *** test/scs_clock_switch_asserts.sv ***
// port assertions for the clock switch sequencer
`timescale 1ns/1ns
`include "scs_regs.vh"
module scs_clock_switch_asserts (
    // watched ports
    input wire        clk_in,
    input wire        rst_n_in,
    input wire        psel_in,
    input wire        penable_in,
    input wire        pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire        pready_out,
    input wire        pslverr_out,
    input wire        crystal_ready_in,
    input wire        pll_ready_in,
    input wire        internal_osc_pll_on_out,
    input wire        pll_enable_out,
    input wire [1:0]  clock_path_out,
    input wire [2:0]  sys_clock_divider_out,
    input wire        radio_clock_enable_out,
    input wire        irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire       wr_done = psel_in & penable_in & pwrite_in & pready_out;
    wire       cfg_wr  = wr_done & (paddr_in == `SCS_OFF_CFG);
    wire [2:0] req_div_next = (pwdata_in[3:1] > 3'h2) ? 3'h2 : pwdata_in[3:1];
    reg  [2:0] req_div_reg;
    // requested divider kept so late checks compare against the clamp
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            req_div_reg <= 3'h0;
        else if (wr_done && paddr_in == `SCS_OFF_CHG_CMD)
            req_div_reg <= req_div_next;
    end
    sequence s_req;
        wr_done && paddr_in == `SCS_OFF_CHG_CMD && pwdata_in[0];
    endsequence
    sequence s_sel;
        cfg_wr && pwdata_in[1] && pwdata_in[7:5] != 3'h0
            && !radio_clock_enable_out;
    endsequence
    a_apb_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (pslverr_out |-> pready_out
        && $past(psel_in && penable_in)) else $error("stray error");
    a_pll_source: assert property ($rose(pll_ready_in) && pll_enable_out
        && clock_path_out == `SCS_PATH_RC
        |-> ##[1:4] clock_path_out == `SCS_PATH_PLL) else $error("no pll");
    a_sel_delay: assert property (s_sel ##0 clock_path_out != `SCS_PATH_XTAL
        |=> (clock_path_out != `SCS_PATH_XTAL)[*3]) else $error("early");
    a_sel_reach: assert property (s_sel ##0 crystal_ready_in[*8]
        |-> clock_path_out == `SCS_PATH_XTAL) else $error("no switch");
    a_stop_power: assert property (cfg_wr && pwdata_in[2] && pwdata_in[1]
        && clock_path_out == `SCS_PATH_XTAL && crystal_ready_in
        |-> ##[1:3] !internal_osc_pll_on_out) else $error("osc kept on");
    a_pll_power: assert property (pll_enable_out |-> internal_osc_pll_on_out)
        else $error("pll on while osc stopped");
    a_xtal_loss: assert property ($fell(crystal_ready_in)
        && clock_path_out == `SCS_PATH_XTAL |-> ##[0:2]
        (clock_path_out != `SCS_PATH_XTAL && internal_osc_pll_on_out))
        else $error("no fallback");
    a_osc_needed: assert property (clock_path_out != `SCS_PATH_XTAL
        |-> ##[0:1] internal_osc_pll_on_out) else $error("osc off");
    a_fast_back: assert property (sys_clock_divider_out == `SCS_DIV_64M
        |-> ##[0:2] clock_path_out != `SCS_PATH_XTAL) else $error("xtal");
    a_req_div: assert property (s_req
        |-> ##[3:7] sys_clock_divider_out == req_div_reg)
        else $error("divider not updated");
    a_done_irq: assert property (s_req ##0 pwdata_in[6] |-> ##[3:8] irq_out)
        else $error("no done interrupt");
    a_irq_hold: assert property (irq_out && !wr_done && !$past(wr_done)
        |=> irq_out) else $error("interrupt dropped");
endmodule // scs_clock_switch_asserts

bind scs_clock_switch scs_clock_switch_asserts u_scs_clock_switch_asserts (
    .clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .pready_out, .pslverr_out, .crystal_ready_in, .pll_ready_in,
    .internal_osc_pll_on_out, .pll_enable_out, .clock_path_out,
    .sys_clock_divider_out, .radio_clock_enable_out, .irq_out
);

// *** test/scs_clock_switch_bench.sv ***
// self-checking bench for the clock switch sequencer
`timescale 1ns/1ns
`include "scs_regs.vh"
module scs_clock_switch_bench;
    reg         clk_in = 1'b0;
    reg         rst_n_in = 1'b0;
    reg         psel_in = 1'b0;
    reg         penable_in = 1'b0;
    reg         pwrite_in = 1'b0;
    reg  [11:0] paddr_in = 12'h000;
    reg  [31:0] pwdata_in = 32'h0;
    reg         crystal_ready_in = 1'b0;
    reg         pll_ready_in = 1'b0;
    reg         pll_lock_in = 1'b0;
    reg         deep_stop_wake_in = 1'b0;
    wire [31:0] prdata_out;
    wire        pready_out, pslverr_out, crystal_enable_out, irq_out;
    wire        internal_osc_pll_on_out, pll_enable_out, radio_clock_enable_out;
    wire [1:0]  clock_path_out, radio_clock_divider_out;
    wire [2:0]  sys_clock_divider_out;
    logic [31:0] rd;
    logic [43:0] rows [0:6];
    integer      fails = 0;
    integer      total_checks = 0;
    integer      i;
    always #10 clk_in = ~clk_in;
    scs_clock_switch u_scs_clock_switch (
        .clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .crystal_ready_in,
        .pll_ready_in, .pll_lock_in, .deep_stop_wake_in, .crystal_enable_out,
        .internal_osc_pll_on_out, .pll_enable_out, .clock_path_out,
        .sys_clock_divider_out, .radio_clock_enable_out,
        .radio_clock_divider_out, .irq_out
    );
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk_in);
    endtask
    // two idle edges at the end: registered outputs of a write have landed
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        integer k;
        k = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        @(posedge clk_in);
        while (pready_out !== 1'b1 && k < 20) begin
            @(posedge clk_in);
            k++;
        end
        if (k == 20)
            fails++;
        rd = prdata_out;
        chk(pslverr_out, a == 12'h004);
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
        @(posedge clk_in);
    endtask
    task finish_test;
        if (fails == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        tick(5000);
        fails++;
        finish_test;
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rows = '{{`SCS_OFF_CTRL, 32'h0}, {`SCS_OFF_CFG, 32'h20},
                 {`SCS_OFF_IRQ_EN, 32'h0}, {`SCS_OFF_IRQ_STAT, 32'h0},
                 {`SCS_OFF_CHG_CMD, 32'h0}, {`SCS_OFF_RADIO, 32'h2},
                 {12'h004, 32'h0}};
        tick(6);
        rst_n_in <= 1'b1;
        for (i = 0; i < 7; i++) begin
            apb(1'b0, rows[i][43:32], 32'h0);
            chk(rd, rows[i][31:0]);
        end
        apb(1'b1, `SCS_OFF_CTRL, 32'h0001_0000);
        chk(crystal_enable_out, 1'b1);
        crystal_ready_in <= 1'b1;
        pll_lock_in <= 1'b1;
        apb(1'b1, `SCS_OFF_CTRL, 32'h0001_1000);
        chk(pll_enable_out, 1'b1);
        pll_ready_in <= 1'b1;
        tick(5);
        chk(clock_path_out, `SCS_PATH_PLL);
        pll_lock_in <= 1'b0;
        tick(3);
        chk(irq_out, 1'b0);
        apb(1'b0, `SCS_OFF_IRQ_STAT, 32'h0);
        chk(rd[5:3], 3'h7);
        apb(1'b1, `SCS_OFF_IRQ_EN, 32'h60);
        tick(2);
        chk(irq_out, 1'b1);
        apb(1'b1, `SCS_OFF_IRQ_CLR, 32'h20);
        tick(2);
        chk(irq_out, 1'b0);
        pll_lock_in <= 1'b1;
        apb(1'b1, `SCS_OFF_CFG, 32'h22);
        tick(6);
        chk(clock_path_out, `SCS_PATH_XTAL);
        apb(1'b1, `SCS_OFF_CFG, 32'h26);
        tick(2);
        chk({internal_osc_pll_on_out, pll_enable_out}, 2'b00);
        crystal_ready_in <= 1'b0;
        tick(3);
        chk(clock_path_out == `SCS_PATH_XTAL, 1'b0);
        chk(internal_osc_pll_on_out, 1'b1);
        crystal_ready_in <= 1'b1;
        apb(1'b1, `SCS_OFF_CFG, 32'h22);
        tick(6);
        apb(1'b1, `SCS_OFF_CFG, 32'h02);
        tick(3);
        chk(clock_path_out == `SCS_PATH_XTAL, 1'b0);
        apb(1'b1, `SCS_OFF_CFG, 32'h22);
        tick(8);
        apb(1'b1, `SCS_OFF_CFG, 32'h20);
        tick(2);
        deep_stop_wake_in <= 1'b1;
        tick(1);
        deep_stop_wake_in <= 1'b0;
        tick(3);
        chk(crystal_enable_out, 1'b1);
        chk(clock_path_out == `SCS_PATH_XTAL, 1'b0);
        apb(1'b1, `SCS_OFF_CFG, 32'h22);
        tick(6);
        chk(clock_path_out, `SCS_PATH_XTAL);
        apb(1'b1, `SCS_OFF_RADIO, 32'h3);
        chk({radio_clock_enable_out, radio_clock_divider_out}, 3'h5);
        apb(1'b1, `SCS_OFF_CFG, 32'h60);
        apb(1'b0, `SCS_OFF_CFG, 32'h0);
        chk(rd[7:5], 3'h1);
        // codes slower than 16 MHz clamp; code 2 runs with the radio at 32 MHz
        for (i = 0; i < 8; i++) begin
            apb(1'b1, `SCS_OFF_CHG_CMD, 32'h41 | (i << 1));
            tick(8);
            chk(irq_out, 1'b1);
            chk(sys_clock_divider_out, (i > 2) ? 2 : i);
            apb(1'b0, `SCS_OFF_CHG_CMD, 32'h0);
            chk(rd[7], 1'b1);
            apb(1'b1, `SCS_OFF_IRQ_CLR, 32'h40);
            tick(2);
            chk(irq_out, 1'b0);
        end
        finish_test;
    end
endmodule // scs_clock_switch_bench
